// File: hw/bptx_pkg.sv
// constants for the transmit backplane timing front end
// assumes a 50 MHz system clock and an Avalon-MM register slave

package bptx_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [3:0]  REG_CONTROL  = 4'h0;
  localparam logic [3:0]  REG_GAP_MASK = 4'h4;
  localparam logic [3:0]  REG_STATUS   = 4'h8;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int          CTRL_WIDTH     = 9;
  localparam int          CTRL_CLK_OUT   = 0;
  localparam int          CTRL_FP_OUT    = 1;
  localparam int          CTRL_FALLING   = 2;
  localparam int          CTRL_E1        = 3;
  localparam int          CTRL_NXDS0     = 4;
  localparam int          CTRL_MULTI     = 5;
  localparam int          CTRL_LOOP      = 6;
  localparam int          CTRL_ILV       = 7;
  localparam int          CTRL_ESF       = 8;
  localparam logic [8:0]  CTRL_RESET     = 9'h000;
  localparam logic [31:0] GAP_RESET      = 32'h0000_0000;

  // ****************************************************************
  // status fields
  // ****************************************************************
  localparam int          ST_POS_LSB     = 0;
  localparam int          ST_FRAME_LSB   = 8;
  localparam int          ST_CRC_LSB     = 16;
  localparam int          ST_ILV         = 24;
  localparam int          ST_CLK_OUT     = 25;
  localparam int          ST_FP_OUT      = 26;

  // ****************************************************************
  // frame geometry, last index of each count
  // ****************************************************************
  localparam logic [7:0]  T1_LAST_BIT    = 8'hc0;
  localparam logic [7:0]  E1_LAST_BIT    = 8'hff;
  localparam logic [4:0]  T1_SF_LAST     = 5'h0b;
  localparam logic [4:0]  T1_ESF_LAST    = 5'h17;
  localparam logic [4:0]  E1_MF_LAST     = 5'h0f;
  localparam logic [3:0]  E1_CRC_LAST    = 4'hf;

  // ****************************************************************
  // lanes of the pin synchroniser
  // ****************************************************************
  localparam int          SYN_W          = 6;
  localparam int          SYN_CLK        = 0;
  localparam int          SYN_REF        = 1;
  localparam int          SYN_REC        = 2;
  localparam int          SYN_FP         = 3;
  localparam int          SYN_PCM        = 4;
  localparam int          SYN_SIG        = 5;

endpackage

// File: hw/bptx_sync.sv
// two-flop synchroniser with edge detection for the backplane pins
// assumes pins are asynchronous to clock and slower than half its rate

`timescale 1ns/1ns
`default_nettype none

module bptx_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             resetn,
  // asynchronous pins
  input  wire logic [WIDTH-1:0] pin,
  // synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;
  } bptx_sync_s;

  bptx_sync_s st;
  bptx_sync_s next_st;

  // meta is read only by stable, never by edge logic
  always_comb begin
    next_st        = st;
    next_st.meta   = pin;
    next_st.stable = st.meta;
    next_st.last   = st.stable;
  end

  // fills through reset: no false edge
  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign level = st.stable;
  assign rise  = st.stable & ~st.last & {WIDTH{resetn}};
  assign fall  = ~st.stable & st.last & {WIDTH{resetn}};

endmodule

`default_nettype wire

// File: hw/bptx_timing.sv
// transmit backplane timing front end: clock, frame pulse, bit sampling
// assumes backplane pins are asynchronous and at most 16.384 MHz,
// registers reached over Avalon-MM with waitrequest
//
// Behaviour
// RULE1: backplane clock input accepted at any rate up to 16.384 MHz, gaps tolerated.
// RULE2: output backplane clock runs at line rate from reference or recovered clock.
// RULE3: T1 sub-rate output clock gapped at framing bit and at masked channels.
// RULE4: E1 sub-rate output clock gapped at masked time slots.
// RULE5: byte-interleaved operation only effective while backplane clock is an input.
// RULE6: one control bit chooses rising or falling active edge.
// RULE7: PCM data and signaling sampled on the active edge.
// RULE8: frame pulse sampled or driven on the active edge.
// RULE9: backplane clock pin is an input after reset.
// RULE10: input frame pulse aligns transmit frame timing.
// RULE11: T1 backplane pulses at multiples of 193 bit periods.
// RULE12: T1 superframe alignment enabled by software, pulse marks frame 1.
// RULE13: E1 backplane pulses at multiples of 256 bit periods.
// RULE14: E1 pulse rise aligns the 16-frame signaling multiframe.
// RULE15: E1 pulse fall aligns the 16-frame CRC multiframe independently.
// RULE16: coincident multiframes give a one-cycle pulse every 16 frames.
// RULE17: output frame pulse high one cycle at first bit of frame or multiframe; none while a sub-rate output clock gaps that bit, as T1 always does.
// RULE18: frame pulse pin is an input after reset.
// RULE19: pulse edges found from successive samples reload the position counters.
// RULE20: counters hold through gaps, advancing only on present active edges; an output clock advances them on every source rise, gapped or not.

`timescale 1ns/1ns
`default_nettype none

module bptx_timing (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // timing references
  input  wire logic        tx_reference_clock_in,
  input  wire logic        rx_recovered_clock,
  // backplane clock pin
  input  wire logic        bp_tx_clock_in,
  output logic             bp_tx_clock_out,
  output logic             bp_tx_clock_oe,
  // backplane frame pulse pin
  input  wire logic        bp_tx_frame_pulse_in,
  output logic             bp_tx_frame_pulse_out,
  output logic             bp_tx_frame_pulse_oe,
  // backplane data pins
  input  wire logic        bp_tx_pcm_data,
  input  wire logic        bp_tx_signaling,
  // towards the transmit framer
  output logic             sample_valid,
  output logic             pcm_bit,
  output logic             signaling_bit,
  output logic             frame_start,
  output logic      [7:0]  bit_position,
  output logic      [4:0]  frame_number,
  output logic      [3:0]  crc_frame_number,
  output logic             interleave_active
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [8:0]  ctrl;
    logic [31:0] gap;
    logic        waitrequest;
    logic [31:0] readdata;
    logic [7:0]  bit_pos;
    logic [4:0]  frame;
    logic [3:0]  crc_frame;
    logic        fp_prev;
    logic        gate;
    logic        clk_out;
    logic        clk_oe;
    logic        fp_out;
    logic        fp_oe;
    logic        smp_valid;
    logic        pcm;
    logic        sig;
    logic        fstart;
    logic        ilv;
  } bptx_state_s;

  bptx_state_s st;
  bptx_state_s next_st;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [bptx_pkg::SYN_W-1:0] syn_pin;
  logic [bptx_pkg::SYN_W-1:0] syn_level;
  logic [bptx_pkg::SYN_W-1:0] syn_rise;
  logic [bptx_pkg::SYN_W-1:0] syn_fall;

  assign syn_pin = {bp_tx_signaling, bp_tx_pcm_data, bp_tx_frame_pulse_in,
                    rx_recovered_clock, tx_reference_clock_in, bp_tx_clock_in};

  // data and clock share the same delay, so sampling stays aligned
  bptx_sync #(
    .WIDTH (bptx_pkg::SYN_W)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .pin    (syn_pin),
    .level  (syn_level),
    .rise   (syn_rise),
    .fall   (syn_fall)
  );

  // ****************************************************************
  // functions
  // ****************************************************************
  // wrapping increment, shared by bit, frame and crc counters
  function automatic logic [7:0] bump(input logic [7:0] val, input logic [7:0] last);
    if (val >= last) begin
      return 8'h00;
    end
    return val + 8'h01;
  endfunction

  // true where the output clock is suppressed for this bit
  function automatic logic gapped(input logic [7:0] pos, input logic [31:0] gap,
                                  input logic e1, input logic subrate);
    logic [7:0] slot;
    slot = pos - 8'h01;
    if (!subrate) begin
      return 1'b0;
    end
    if (e1) begin
      return gap[pos[7:3]]; // RULE4
    end
    if (pos == 8'h00) begin
      return 1'b1; // RULE3
    end
    return gap[slot[7:3]]; // RULE3
  endfunction

  // byte-enabled register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdata,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic        clk_output;
    logic        falling;
    logic        e1;
    logic        src_level;
    logic        src_rise;
    logic        src_fall;
    logic        tick_in;
    logic        adv;
    logic        smp;
    logic        fp_in;
    logic        fp_rise;
    logic        fp_fall;
    logic [7:0]  last_bit;
    logic [4:0]  last_frame;
    logic [31:0] wr_val;
    logic [31:0] rd_val;
    logic [8:0]  new_ctrl;

    next_st   = st;
    clk_output = st.ctrl[bptx_pkg::CTRL_CLK_OUT];
    falling    = st.ctrl[bptx_pkg::CTRL_FALLING];
    e1         = st.ctrl[bptx_pkg::CTRL_E1];
    wr_val     = 32'h0000_0000;
    rd_val     = 32'h0000_0000;
    new_ctrl   = st.ctrl;

    // ****************************************************************
    // register bus: one wait cycle, then answer
    // ****************************************************************
    if ((avs_read || avs_write) && st.waitrequest) begin
      next_st.waitrequest = 1'b0;
      case (avs_address)
        bptx_pkg::REG_CONTROL: begin
          rd_val = {23'h000000, st.ctrl};
        end
        bptx_pkg::REG_GAP_MASK: begin
          rd_val = st.gap;
        end
        bptx_pkg::REG_STATUS: begin
          rd_val[bptx_pkg::ST_POS_LSB +: 8]   = st.bit_pos;
          rd_val[bptx_pkg::ST_FRAME_LSB +: 5] = st.frame;
          rd_val[bptx_pkg::ST_CRC_LSB +: 4]   = st.crc_frame;
          rd_val[bptx_pkg::ST_ILV]            = st.ilv;
          rd_val[bptx_pkg::ST_CLK_OUT]        = st.clk_oe;
          rd_val[bptx_pkg::ST_FP_OUT]         = st.fp_oe;
        end
        default: begin
          rd_val = 32'h0000_0000;
        end
      endcase
      next_st.readdata = avs_read ? rd_val : 32'h0000_0000;
    end else begin
      next_st.waitrequest = 1'b1;
    end

    // writes land on the edge where the master sees waitrequest low
    if (avs_write && !st.waitrequest) begin
      case (avs_address)
        bptx_pkg::REG_CONTROL: begin
          wr_val   = merge({23'h000000, st.ctrl}, avs_writedata, avs_byteenable);
          new_ctrl = wr_val[8:0];
        end
        bptx_pkg::REG_GAP_MASK: begin
          next_st.gap = merge(st.gap, avs_writedata, avs_byteenable);
        end
        default: begin
          next_st.gap = st.gap;
        end
      endcase
    end
    next_st.ctrl = new_ctrl;

    // ****************************************************************
    // edge selection
    // ****************************************************************
    // loop timing picks the recovered clock as line reference
    if (st.ctrl[bptx_pkg::CTRL_LOOP]) begin // RULE2
      src_level = syn_level[bptx_pkg::SYN_REC];
      src_rise  = syn_rise[bptx_pkg::SYN_REC];
      src_fall  = syn_fall[bptx_pkg::SYN_REC];
    end else begin
      src_level = syn_level[bptx_pkg::SYN_REF];
      src_rise  = syn_rise[bptx_pkg::SYN_REF];
      src_fall  = syn_fall[bptx_pkg::SYN_REF];
    end

    // an absent edge in a gapped input clock simply never ticks
    tick_in = falling ? syn_fall[bptx_pkg::SYN_CLK] : syn_rise[bptx_pkg::SYN_CLK]; // RULE6 RULE1

    if (clk_output) begin
      adv = src_rise; // RULE2
      smp = (falling ? src_fall : src_rise) & st.gate; // RULE6
    end else begin
      adv = tick_in; // RULE20
      smp = tick_in;
    end

    // ****************************************************************
    // position counters
    // ****************************************************************
    last_bit   = e1 ? bptx_pkg::E1_LAST_BIT : bptx_pkg::T1_LAST_BIT;
    if (e1) begin
      last_frame = bptx_pkg::E1_MF_LAST;
    end else if (st.ctrl[bptx_pkg::CTRL_ESF]) begin
      last_frame = bptx_pkg::T1_ESF_LAST;
    end else begin
      last_frame = bptx_pkg::T1_SF_LAST;
    end

    if (adv) begin // RULE20
      next_st.bit_pos = bump(st.bit_pos, last_bit);
      if (st.bit_pos >= last_bit) begin
        next_st.frame     = 5'(bump({3'h0, st.frame}, {3'h0, last_frame}));
        next_st.crc_frame = 4'(bump({4'h0, st.crc_frame}, {4'h0, bptx_pkg::E1_CRC_LAST}));
      end
    end

    // ****************************************************************
    // frame pulse input alignment
    // ****************************************************************
    fp_in   = syn_level[bptx_pkg::SYN_FP];
    fp_rise = smp & fp_in & ~st.fp_prev; // RULE19
    fp_fall = smp & ~fp_in & st.fp_prev; // RULE19
    if (smp) begin
      next_st.fp_prev = fp_in; // RULE8
    end

    if (!st.ctrl[bptx_pkg::CTRL_FP_OUT]) begin
      // a held pulse realigns bit (and frame in multiframe mode) once, on its rise only; E1 multiframe mode also realigns crc on its fall
      if (fp_rise) begin
        next_st.bit_pos = 8'h00; // RULE10 RULE11 RULE13
        if (st.ctrl[bptx_pkg::CTRL_MULTI]) begin
          next_st.frame = 5'h00; // RULE12 RULE14
          if (!e1) begin
            next_st.crc_frame = 4'h0;
          end
        end
      end
      if (fp_fall && e1 && st.ctrl[bptx_pkg::CTRL_MULTI]) begin
        next_st.crc_frame = 4'h0; // RULE15 RULE16
      end
    end

    // ****************************************************************
    // bit sampling towards the framer
    // ****************************************************************
    next_st.smp_valid = smp;
    next_st.fstart    = 1'b0;
    if (smp) begin
      next_st.pcm    = syn_level[bptx_pkg::SYN_PCM]; // RULE7
      next_st.sig    = syn_level[bptx_pkg::SYN_SIG]; // RULE7
      next_st.fstart = (next_st.bit_pos == 8'h00);
    end

    // ****************************************************************
    // frame pulse output
    // ****************************************************************
    // only meaningful up to 2.048 MHz; faster rates are not checked
    if (st.ctrl[bptx_pkg::CTRL_FP_OUT]) begin
      if (smp) begin
        next_st.fp_out = (next_st.bit_pos == 8'h00) &&
                         (!st.ctrl[bptx_pkg::CTRL_MULTI] || next_st.frame == 5'h00); // RULE17 RULE8
      end
    end else begin
      next_st.fp_out = 1'b0;
    end
    next_st.fp_oe = st.ctrl[bptx_pkg::CTRL_FP_OUT]; // RULE18

    // ****************************************************************
    // backplane clock output and gapping
    // ****************************************************************
    // gate changes only while the source is low, so no runt pulses
    if (src_fall) begin
      next_st.gate = ~gapped(bump(st.bit_pos, last_bit), st.gap, e1,
                             st.ctrl[bptx_pkg::CTRL_NXDS0]); // RULE3 RULE4
    end
    next_st.clk_out = clk_output & src_level & st.gate; // RULE2
    next_st.clk_oe  = clk_output; // RULE9

    // interleaving is refused while the device drives the clock
    next_st.ilv = st.ctrl[bptx_pkg::CTRL_ILV] & ~clk_output; // RULE5
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st             <= '0;
      st.ctrl        <= bptx_pkg::CTRL_RESET; // RULE9 RULE18
      st.gap         <= bptx_pkg::GAP_RESET;
      st.waitrequest <= 1'b1;
      st.gate        <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata          = st.readdata;
  assign avs_waitrequest       = st.waitrequest;
  assign bp_tx_clock_out       = st.clk_out;
  assign bp_tx_clock_oe        = st.clk_oe;
  assign bp_tx_frame_pulse_out = st.fp_out;
  assign bp_tx_frame_pulse_oe  = st.fp_oe;
  assign sample_valid          = st.smp_valid;
  assign pcm_bit               = st.pcm;
  assign signaling_bit         = st.sig;
  assign frame_start           = st.fstart;
  assign bit_position          = st.bit_pos;
  assign frame_number          = st.frame;
  assign crc_frame_number      = st.crc_frame;
  assign interleave_active     = st.ilv;

endmodule

`default_nettype wire

// File: sim/bptx_timing_checker.sv
// assertions on the ports of the backplane transmit timing block
// assumes one clock domain, bound to every bptx_timing instance
`timescale 1ns/1ns
`default_nettype none
module bptx_timing_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // register bus
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  // pins
  input wire logic       bp_tx_clock_oe,
  input wire logic       bp_tx_frame_pulse_out,
  input wire logic       bp_tx_frame_pulse_oe,
  // framer side
  input wire logic       sample_valid,
  input wire logic       frame_start,
  input wire logic [7:0] bit_position,
  input wire logic [4:0] frame_number,
  input wire logic [3:0] crc_frame_number,
  input wire logic       interleave_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ****
  // properties
  // ****
  a_pins_after_reset: assert property (
    $rose(resetn) |-> !bp_tx_clock_oe && !bp_tx_frame_pulse_oe) else $error("pin not input");
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_bus_stands: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
  a_valid_pulse: assert property (sample_valid |=> !sample_valid) else $error("long sample");
  a_start_bit0: assert property (
    frame_start |-> sample_valid && bit_position == 8'h00) else $error("start off bit 0");
  // output mode may advance on gapped edges, so input mode only
  a_bit_advance: assert property (
    !bp_tx_clock_oe && !$past(bp_tx_clock_oe) && sample_valid && !frame_start
    |-> bit_position == $past(bit_position) + 8'h01) else $error("bit skipped");
  a_gap_hold: assert property (
    !bp_tx_clock_oe && !$past(bp_tx_clock_oe) && !sample_valid
    |-> $stable(bit_position) && $stable(frame_number) && $stable(crc_frame_number))
    else $error("counter moved");
  a_fp_out_bit0: assert property (
    bp_tx_frame_pulse_oe && $rose(bp_tx_frame_pulse_out) |-> bit_position == 8'h00)
    else $error("pulse off bit 0");
  a_fp_out_short: assert property (
    $rose(bp_tx_frame_pulse_out) |-> ##[1:64] !bp_tx_frame_pulse_out) else $error("long pulse");
  a_ilv_input: assert property (interleave_active |-> !bp_tx_clock_oe) else $error("ilv");
  c_frame: cover property (frame_start);
  c_fp_out: cover property ($rose(bp_tx_frame_pulse_out));
  c_ilv: cover property (interleave_active);
endmodule
bind bptx_timing bptx_timing_checker i_bptx_timing_checker (
  .clock(clock), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .bp_tx_clock_oe(bp_tx_clock_oe),
  .bp_tx_frame_pulse_out(bp_tx_frame_pulse_out), .bp_tx_frame_pulse_oe(bp_tx_frame_pulse_oe),
  .sample_valid(sample_valid), .frame_start(frame_start), .bit_position(bit_position),
  .frame_number(frame_number), .crc_frame_number(crc_frame_number),
  .interleave_active(interleave_active));
`default_nettype wire

// File: sim/bptx_backplane_model.sv
// backplane source model: clock, frame pulse, pcm and signaling
// assumes mode inputs are settled before run rises; two frames a run
`timescale 1ns/1ns
`default_nettype none
module bptx_backplane_model (
  // mode
  input  wire logic run,
  input  wire logic e1,
  input  wire logic multi,
  input  wire logic falling,
  input  wire logic gap,
  // pins
  output logic      clk,
  output logic      fp,
  output logic      pcm,
  output logic      sig,
  output logic      done
);
  int b;
  int f;
  int len;
  initial begin
    {clk, fp, pcm, sig, done} = 5'h00;
    forever begin
      wait (run || (clk != !falling));
      #5 clk = !falling; // idle just past an active edge, so no stray sample
      if (run) begin
        done = 1'b0;
        len = e1 ? 256 : 193;
        for (f = 0; f < 2; f++)
          for (b = 0; b < len; b++) begin
            #80 clk = falling;
            // data moves between the edges: a wrong-edge sampler sees the old bit
            #40 pcm = b[0] ^ b[4];
            sig = b[1];
            fp = (b == 0) && (!multi || f == 0);
            #40 clk = !falling;
            if (gap && b[2:0] == 3'h7) #320;
          end
        done = 1'b1;
        wait (!run);
        #25 pcm = !pcm;
        sig = !sig;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the backplane transmit timing block
// assumes the checker and backplane model are compiled before it
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clock, resetn, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        ref_clk, rec_clk, ref_en, rec_en, loop, run, e1, multi, falling, gap, done;
  logic        m_clk, m_fp, m_pcm, m_sig, pin_clk, pin_fp, counting, aligned;
  logic        bp_tx_clock_out, bp_tx_clock_oe, bp_tx_frame_pulse_out, bp_tx_frame_pulse_oe;
  logic        sample_valid, pcm_bit, signaling_bit, frame_start, interleave_active;
  logic [7:0]  bit_position;
  logic [4:0]  frame_number;
  logic [3:0]  crc_frame_number;
  int          fails, n_compared, nsamp, nsrc, nout;
  logic [8:0]  sc [6] = '{9'h000, 9'h004, 9'h008, 9'h028, 9'h020, 9'h120};
  logic [8:0]  oc [4] = '{9'h003, 9'h043, 9'h011, 9'h019};
  logic [31:0] om [4] = '{32'h0, 32'h0, 32'h1, 32'h2};
  int          ow [4] = '{193, 193, 386, 512};
  int          ox [4] = '{193, 193, 368, 496};
  // pin level resolved from both parties
  assign pin_clk = bp_tx_clock_oe ? bp_tx_clock_out : m_clk;
  assign pin_fp  = bp_tx_frame_pulse_oe ? bp_tx_frame_pulse_out : m_fp;
  bptx_timing i_bptx_timing (.clock(clock), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tx_reference_clock_in(ref_clk),
    .rx_recovered_clock(rec_clk), .bp_tx_clock_in(pin_clk), .bp_tx_clock_out(bp_tx_clock_out),
    .bp_tx_clock_oe(bp_tx_clock_oe), .bp_tx_frame_pulse_in(pin_fp),
    .bp_tx_frame_pulse_out(bp_tx_frame_pulse_out), .bp_tx_frame_pulse_oe(bp_tx_frame_pulse_oe),
    .bp_tx_pcm_data(m_pcm), .bp_tx_signaling(m_sig), .sample_valid(sample_valid),
    .pcm_bit(pcm_bit), .signaling_bit(signaling_bit), .frame_start(frame_start),
    .bit_position(bit_position), .frame_number(frame_number),
    .crc_frame_number(crc_frame_number), .interleave_active(interleave_active));
  bptx_backplane_model i_bptx_backplane_model (.run(run), .e1(e1), .multi(multi),
    .falling(falling), .gap(gap), .clk(m_clk), .fp(m_fp), .pcm(m_pcm), .sig(m_sig),
    .done(done));
  // ****
  // clocks and monitors
  // ****
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    ref_clk = 1'b0;
    forever #80 ref_clk = ref_en & ~ref_clk;
  end
  initial begin
    rec_clk = 1'b0;
    forever #200 rec_clk = rec_en & ~rec_clk;
  end
  always @(posedge ref_clk) if (counting && !loop) nsrc++;
  always @(posedge rec_clk) if (counting && loop) nsrc++;
  always @(posedge bp_tx_clock_out) if (counting) nout++;
  always @(posedge clock) begin
    if (sample_valid === 1'b1 && counting) nsamp++;
    if (sample_valid === 1'b1 && aligned) begin
      check(pcm_bit, bit_position[0] ^ bit_position[4]);
      check(signaling_bit, bit_position[1]);
      check(frame_start, bit_position == 8'h00);
    end
    aligned <= run && (aligned || frame_start === 1'b1);
  end
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clock);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    check(n, 2);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd & mask, exp);
  endtask
  task automatic stream(input logic [8:0] c);
    int len;
    len = c[3] ? 256 : 193;
    bus(1'b1, 4'h0, {23'h0, c}, 4'hf);
    falling <= c[2];
    e1 <= c[3];
    multi <= c[5];
    repeat (20) @(posedge clock);
    nsamp = 0;
    counting = 1'b1;
    run <= 1'b1;
    @(posedge clock);
    wait (done === 1'b1);
    repeat (10) @(posedge clock);
    counting = 1'b0;
    run <= 1'b0;
    check(nsamp, 2 * len);
  endtask
  task automatic print_verdict;
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    {resetn, avs_read, avs_write, ref_en, rec_en, loop, run, e1, multi} = 9'h000;
    {falling, gap, counting, aligned} = 4'h0;
    {avs_address, avs_byteenable, avs_writedata} = 40'h0;
    {fails, n_compared, nsamp, nsrc, nout} = 160'h0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    rdchk(4'h0, 32'hffff_ffff, 32'h0);
    rdchk(4'h8, 32'h0700_0000, 32'h0);
    bus(1'b1, 4'h0, 32'h1ff, 4'h1);
    rdchk(4'h0, 32'hffff_ffff, 32'h0ff);
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
    rdchk(4'hc, 32'hffff_ffff, 32'h0);
    bus(1'b1, 4'h8, 32'hffff_ffff, 4'hf);
    rdchk(4'h8, 32'h0700_0000, 32'h0600_0000);
    bus(1'b1, 4'h0, 32'h080, 4'hf);
    rdchk(4'h8, 32'h0700_0000, 32'h0100_0000);
    check(interleave_active, 1'b1);
    for (int i = 0; i < 6; i++) begin
      gap <= (i == 1);
      stream(sc[i]);
      rdchk(4'h8, sc[i][5] ? (sc[i][3] ? 32'h000f_1fff : 32'h1fff) : 32'hff,
            {12'h0, 4'h1, 3'h0, 5'h01, sc[i][3] ? 8'hff : 8'hc0}
            & (sc[i][5] ? (sc[i][3] ? 32'h000f_1fff : 32'h1fff) : 32'hff));
    end
    for (int i = 0; i < 4; i++) begin
      loop = oc[i][6];
      ref_en <= !oc[i][6];
      rec_en <= oc[i][6];
      bus(1'b1, 4'h4, om[i], 4'hf);
      bus(1'b1, 4'h0, {23'h0, oc[i]}, 4'hf);
      repeat (100) @(posedge clock);
      check(bp_tx_frame_pulse_oe, oc[i][1]);
      {nsrc, nout} = 64'h0;
      counting = 1'b1;
      while (nsrc < ow[i]) @(posedge clock);
      counting = 1'b0;
      check(nout - ox[i] + 2 <= 4 && nout - ox[i] + 2 >= 0, 1'b1);
    end
    print_verdict();
  end
  initial begin
    #2_000_000;
    check(32'h0, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
